// >>> logic/msc_regs.v
// Operation
// - Preamble-pass bit 0 pads odd-nibble preambles, 1 passes them; resets to 1.
// - Receive-clock bit 1 keeps clock running in power down, 0 lets it stop.
// - New receive-clock bit value applies only after a software reset.
// - Interrupt enables at bits 7, 3, 2, each resetting to 0.
// - Status bit 7 latches high on copper FIFO overflow or underflow.
// - Status bit 3 latches high when the FIFO inserts an idle.
// - Status bit 2 latches high when the FIFO deletes an idle.
`timescale 1ns/10ps
`include "msc_map.vh"
module msc_regs (
  input  wire                     clk,           // 20 MHz clock.
  input  wire                     rst_n,         // Synchronous reset, active low.
  input  wire [`MSC_ADDR_W-1:0]   addr,          // Register address.
  input  wire [`MSC_DATA_W-1:0]   wdata,         // Write data.
  input  wire                     wr,            // Write strobe.
  input  wire                     rd,            // Read strobe.
  output reg  [`MSC_DATA_W-1:0]   rdata,         // Read data, cycle after rd.
  input  wire                     fifo_err_pin,  // FIFO over/underflow, async.
  input  wire                     idle_ins_pin,  // Idle inserted, async.
  input  wire                     idle_del_pin,  // Idle deleted, async.
  output reg                      pad_odd_pre,   // 1 pads odd-nibble preambles.
  output reg                      rxclk_keep_on, // 1 keeps receive clock running.
  output reg                      int_req,       // Field-enabled interrupt level.
  output reg                      irq            // Masked sticky event interrupt.
);
  reg  [`MSC_DATA_W-1:0] ctrl_one;
  reg  [`MSC_DATA_W-1:0] int_en;
  reg  [`MSC_DATA_W-1:0] evt_mask;
  reg  [`MSC_DATA_W-1:0] evt_stat;
  reg  [2:0]             swrst_cnt;
  reg                    sw_rst;
  wire                   fifo_err;
  wire                   idle_ins;
  wire                   idle_del;
  wire                   f_err;
  wire                   f_ins;
  wire                   f_del;
  wire                   stat_rd;
  wire [`MSC_DATA_W-1:0] status;
  wire [`MSC_DATA_W-1:0] evt_now;

  // Places the three FIFO event bits; used for the status word and the live event word.
  function [`MSC_DATA_W-1:0] msc_place;
    input e;
    input i;
    input d;
    begin
      msc_place = 16'h0000;
      msc_place[`MSC_BIT_FIFO_ERR] = e;
      msc_place[`MSC_BIT_IDLE_INS] = i;
      msc_place[`MSC_BIT_IDLE_DEL] = d;
    end
  endfunction

  msc_sync u_s_err (.clk(clk), .rst_n(rst_n), .d(fifo_err_pin), .q(fifo_err));
  msc_sync u_s_ins (.clk(clk), .rst_n(rst_n), .d(idle_ins_pin), .q(idle_ins));
  msc_sync u_s_del (.clk(clk), .rst_n(rst_n), .d(idle_del_pin), .q(idle_del));

  assign stat_rd = rd && (addr == `MSC_OFS_STATUS);

  msc_flag u_f_err (.clk(clk), .rst_n(rst_n), .sw_rst(sw_rst), .cond(fifo_err),
                    .rd_clr(stat_rd), .flag(f_err));
  msc_flag u_f_ins (.clk(clk), .rst_n(rst_n), .sw_rst(sw_rst), .cond(idle_ins),
                    .rd_clr(stat_rd), .flag(f_ins));
  msc_flag u_f_del (.clk(clk), .rst_n(rst_n), .sw_rst(sw_rst), .cond(idle_del),
                    .rd_clr(stat_rd), .flag(f_del));

  assign status  = msc_place(f_err, f_ins, f_del);
  assign evt_now = msc_place(fifo_err, idle_ins, idle_del);

  // Software reset: a write of bit 15 to the reset register, held a few cycles.
  always @(posedge clk) begin
    if (!rst_n) begin
      swrst_cnt <= 3'h0;
      sw_rst    <= 1'b0;
    end else if (wr && addr == `MSC_OFS_SW_RESET && wdata[15]) begin
      swrst_cnt <= `MSC_SWRST_CYCLES;
      sw_rst    <= 1'b1;
    end else if (swrst_cnt != 3'h0) begin
      swrst_cnt <= swrst_cnt - 3'h1;
      sw_rst    <= (swrst_cnt != 3'h1);
    end else begin
      sw_rst    <= 1'b0;
    end
  end

  // Control and enable registers retain their contents over a software reset.
  // Reserved bits are stored as written, except in the event mask, which keeps only bits 7, 3, 2; software keeps them at reset values.
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_one <= `MSC_CTRL_RST;
      int_en   <= `MSC_INT_EN_RST;
      evt_mask <= `MSC_EVT_MASK_RST;
    end else if (wr) begin
      if (addr == `MSC_OFS_CTRL_ONE)
        ctrl_one <= wdata & `MSC_CTRL_RW_MASK;
      if (addr == `MSC_OFS_INT_EN)
        int_en <= wdata;
      if (addr == `MSC_OFS_INT_MASK)
        evt_mask <= wdata & `MSC_INT_EN_MASK;
    end
  end

  // Preamble handling follows the bit at once; the receive-clock choice is
  // sampled only on software reset, as changing it live would glitch the clock.
  always @(posedge clk) begin
    if (!rst_n) begin
      pad_odd_pre   <= 1'b0;
      rxclk_keep_on <= 1'b1;
    end else begin
      pad_odd_pre <= ~ctrl_one[`MSC_BIT_PASS_ODD];
      if (sw_rst)
        rxclk_keep_on <= ctrl_one[`MSC_BIT_RXCLK_ON];
    end
  end

  // Sticky event register, write one to clear; a new event wins over the clear.
  always @(posedge clk) begin
    if (!rst_n) begin
      evt_stat <= 16'h0000;
    end else if (wr && addr == `MSC_OFS_EVT_STAT) begin
      evt_stat <= (evt_stat & ~wdata) | evt_now;
    end else begin
      evt_stat <= evt_stat | evt_now;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      int_req <= 1'b0;
      irq     <= 1'b0;
    end else begin
      int_req <= |(status & int_en & `MSC_INT_EN_MASK);
      irq     <= |(evt_stat & evt_mask);
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `MSC_OFS_CTRL_ONE: rdata <= ctrl_one;
        `MSC_OFS_INT_EN:   rdata <= int_en;
        `MSC_OFS_STATUS:   rdata <= status;
        `MSC_OFS_INT_MASK: rdata <= evt_mask;
        `MSC_OFS_EVT_STAT: rdata <= evt_stat;
        default:           rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule

// >>> logic/msc_map.vh
`ifndef MSC_MAP_VH
`define MSC_MAP_VH
`define MSC_ADDR_W          5
`define MSC_DATA_W          16
`define MSC_OFS_CTRL_ONE    5'h10
`define MSC_OFS_INT_EN      5'h12
`define MSC_OFS_STATUS      5'h13
`define MSC_OFS_SW_RESET    5'h1C
`define MSC_OFS_INT_MASK    5'h1D
`define MSC_OFS_EVT_STAT    5'h1E
`define MSC_BIT_PASS_ODD    6
`define MSC_BIT_RXCLK_ON    3
`define MSC_BIT_FIFO_ERR    7
`define MSC_BIT_IDLE_INS    3
`define MSC_BIT_IDLE_DEL    2
`define MSC_CTRL_RST        16'h4448
`define MSC_CTRL_RW_MASK    16'hFFFF
`define MSC_INT_EN_RST      16'h0000
`define MSC_INT_EN_MASK     16'h008C
`define MSC_EVT_MASK_RST    16'h0000
`define MSC_SWRST_CYCLES    3'h4
`endif

// >>> logic/msc_flag.v
`timescale 1ns/10ps
// One latched-high status flag with clear-on-read that a live condition survives.
module msc_flag (
  input  wire clk,       // Clock.
  input  wire rst_n,     // Synchronous reset, active low.
  input  wire sw_rst,    // Soft reset pulse.
  input  wire cond,      // Triggering condition, same clock.
  input  wire rd_clr,    // Status read pulse.
  output reg  flag       // Latched flag.
);
  always @(posedge clk) begin
    if (!rst_n || sw_rst) begin
      flag <= 1'b0;
    end else if (cond) begin
      flag <= 1'b1;
    end else if (rd_clr) begin
      flag <= 1'b0;
    end
  end
endmodule

// >>> logic/msc_sync.v
`timescale 1ns/10ps
// Two flip-flop synchroniser for a level from outside the clock domain.
module msc_sync (
  input  wire clk,      // Clock.
  input  wire rst_n,    // Synchronous reset, active low.
  input  wire d,        // Asynchronous level.
  output reg  q         // Synchronised level.
);
  reg stage1;
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      q      <= 1'b0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule

// >>> verification/msc_fifo_src.sv
`timescale 1ns/10ps
// Copper FIFO event source; pins move 13 ns after the edge, as from a foreign domain.
module msc_fifo_src (
  input  wire       clk, // Clock.
  input  wire [2:0] ev,  // Requested levels.
  output reg  [2:0] pin  // Error, insert, delete.
);
  initial pin = 3'h0;
  always @(posedge clk) pin <= #13 ev;
endmodule

// >>> verification/msc_chk.sv
`timescale 1ns/10ps
module msc_chk (
  input wire        clk,           // Clock.
  input wire        rst_n,         // Reset.
  input wire [4:0]  addr,          // Address.
  input wire [15:0] wdata,         // Data.
  input wire        wr,            // Write.
  input wire        rd,            // Read.
  input wire [15:0] rdata,         // Read data.
  input wire        pad_odd_pre,   // Pad.
  input wire        rxclk_keep_on, // Clock hold.
  input wire        int_req,       // Interrupt.
  input wire        irq            // Event irq.
);
  reg [3:0] acc_age, sw_age;
  // Ages saturate so that a long quiet spell never wraps back into range.
  always @(posedge clk) begin
    acc_age <= (!rst_n || wr || rd) ? 4'h0 : acc_age + {3'h0, ~&acc_age};
    sw_age <= (!rst_n || (wr && addr == 5'h1C && wdata[15])) ? 4'h0 : sw_age + {3'h0, ~&sw_age};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("rdata outside read");
  a_st_rsvd: assert property ($past(rd && addr == 5'h13) |-> (rdata & 16'hFF73) == 16'h0000)
    else $error("reserved status set");
  a_pad_load: assert property (wr && addr == 5'h10 |-> ##2
    pad_odd_pre == !$past(wdata[6], 2))
    else $error("pad wrong");
  a_pad_hold: assert property ($changed(pad_odd_pre) |-> $past(wr && addr == 5'h10, 2))
    else $error("pad moved");
  a_rxclk_swrst: assert property ($changed(rxclk_keep_on) |-> sw_age <= 4'h5)
    else $error("clock hold moved");
  a_int_fall: assert property ($fell(int_req) |-> acc_age <= 4'h8)
    else $error("int_req fell alone");
  a_int_rise: assert property ($rose(int_req) |-> !$past(rd))
    else $error("int_req rose on read");
  a_irq_fall: assert property ($fell(irq) |-> acc_age <= 4'h8)
    else $error("irq fell alone");
endmodule
bind msc_regs msc_chk chk_u (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .pad_odd_pre,
  .rxclk_keep_on, .int_req, .irq);

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  reg         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  reg  [4:0]  addr = 5'h00;
  reg  [15:0] wdata = 16'h0000, v, m;
  reg  [2:0]  ev = 3'h0;
  reg  [15:0] exp_q[$];
  wire [2:0]  pin;
  wire [15:0] rdata;
  wire        pad_odd_pre, rxclk_keep_on, int_req, irq;
  wire [15:0] outs = {12'h000, pad_odd_pre, rxclk_keep_on, int_req, irq};
  int         failures = 0, num_checks = 0, i;
  always #25 clk = ~clk;
  msc_fifo_src src_u (.clk, .ev, .pin);
  msc_regs dut_u (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .fifo_err_pin(pin[2]),
    .idle_ins_pin(pin[1]), .idle_del_pin(pin[0]), .pad_odd_pre, .rxclk_keep_on, .int_req, .irq);
  task report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cmp(input [15:0] e, input [15:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t expected %h got %h", $time, e, g);
    end
  endtask
  // Outputs move at the rising edge, so they are looked at on the falling edge.
  task co(input [15:0] e);
    @(negedge clk);
    cmp(e, outs);
    @(posedge clk);
  endtask
  // The idle cycle after each strobe keeps every signal to one assignment per time step.
  task acc(input w, input [4:0] a, input [15:0] d);
    if (!w) exp_q.push_back(d);
    {addr, wdata, wr, rd} <= {a, d, w, !w};
    @(posedge clk);
    {wr, rd} <= 2'h0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) cmp(exp_q.pop_front(), rdata);
  end
  initial begin
    v = $urandom(32'hAE40);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, 5'h10, 16'h4448);
    acc(0, 5'h12, 16'h0000);
    acc(0, 5'h05, 16'h0000);
    co(16'h0004);
    v = 16'h4400 | ($urandom & 16'h0040);
    acc(1, 5'h10, v);
    acc(1, 5'h1C, 16'h8000);
    repeat (6) @(posedge clk);
    co({12'h000, ~v[6], 3'h0});
    acc(1, 5'h10, 16'h4448);
    v = $urandom;
    acc(1, 5'h12, v);
    acc(0, 5'h12, v);
    co(16'h0000);
    acc(1, 5'h1D, 16'h008C);
    for (i = 0; i < 3; i++) begin
      m = 16'h0080 >> (i == 0 ? 0 : i + 3);
      acc(1, 5'h12, v & 16'hFF73);
      ev <= 3'h4 >> i;
      repeat (6) @(posedge clk);
      ev <= 3'h0;
      repeat (6) @(posedge clk);
      co(16'h0001);
      acc(1, 5'h12, 16'h008C);
      acc(0, 5'h1E, m);
      co(16'h0003);
      acc(0, 5'h13, m);
      acc(0, 5'h13, 16'h0000);
      acc(1, 5'h1E, m);
      co(16'h0000);
    end
    ev <= 3'h2;
    repeat (6) @(posedge clk);
    acc(0, 5'h13, 16'h0008);
    acc(0, 5'h13, 16'h0008);
    co(16'h0003);
    report_and_stop;
  end
endmodule
